// ### rtl/sfpi_buf2.sv
// two-entry byte buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
`include "sfpi_params.svh"

module sfpi_buf2
    import sfpi_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   sys_rst,
    // filling side
    sfpi_stream_if.snk  fill,
    // draining side
    sfpi_stream_if.src  drain
);

    sfpi_byte_t head;
    sfpi_byte_t tail;
    logic       head_valid;
    logic       tail_valid;
    logic       push;
    logic       pop;

    // ready drops only when both entries are full
    assign fill.ready  = ~tail_valid;
    assign drain.data  = head;
    assign drain.valid = head_valid;
    assign push        = fill.valid & ~tail_valid;
    assign pop         = head_valid & drain.ready;

    // ----------------
    // entry storage
    // ----------------
    // head always holds the oldest word; tail moves up on a pop
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            head_valid <= 1'b0;
            tail_valid <= 1'b0;
            head       <= `SFPI_RX_RESET;
            tail       <= `SFPI_RX_RESET;
        end
        else
        begin
            unique case ({push, pop})
                2'b10:
                begin
                    if (head_valid)
                    begin
                        tail       <= fill.data;
                        tail_valid <= 1'b1;
                    end
                    else
                    begin
                        head       <= fill.data;
                        head_valid <= 1'b1;
                    end
                end
                2'b01:
                begin
                    head       <= tail;
                    head_valid <= tail_valid;
                    tail_valid <= 1'b0;
                end
                2'b11:
                begin
                    head       <= tail_valid ? tail : fill.data;
                    tail       <= fill.data;
                end
                default: ;
            endcase
        end
    end

endmodule : sfpi_buf2

`default_nettype wire

// ### rtl/sfpi_front.sv
// pin-level serial front end of a small serial flash device
`timescale 1ns/100ps
`default_nettype none
`include "sfpi_params.svh"

module sfpi_front
    import sfpi_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          sys_rst,
    // link pins
    input  wire logic          chip_select_n,
    input  wire logic          serial_clk,
    input  wire logic [3:0]    data_line_in,
    output var  logic [3:0]    data_line_out,
    output var  logic [3:0]    data_line_oe,
    // configuration from the device core
    input  wire logic          quad_enable_bit,
    input  wire logic          four_line_command_mode,
    input  wire sfpi_lanes_e   lane_mode,
    input  wire logic          read_phase,
    input  wire logic          program_phase,
    input  wire logic          status_protect_bits,
    input  wire logic          internal_cycle_busy,
    // received bytes
    output var  sfpi_byte_t    rx_data,
    output var  logic          rx_valid,
    input  wire logic          rx_ready,
    // bytes to send
    input  wire sfpi_byte_t    tx_data,
    input  wire logic          tx_valid,
    output var  logic          tx_ready,
    // status to the device core
    output var  logic          selected,
    output var  logic          paused,
    output var  logic          frame_start,
    output var  logic          mode_refused,
    output var  logic          status_write_allowed,
    output var  logic          standby,
    output var  logic [8:0]    prog_byte_count,
    output var  logic          page_overflow,
    output var  logic          rx_overrun,
    output var  logic          tx_underrun
);

    // ----------------
    // helpers
    // ----------------
    // bits moved per clock edge for a lane setting
    function automatic logic [3:0] lane_bits(input sfpi_lanes_e lanes);
        logic [3:0] bits;
        bits = 4'h1;
        unique case (lanes)
            LANES_ONE:  bits = 4'h1;
            LANES_TWO:  bits = 4'h2;
            LANES_FOUR: bits = 4'h4;
            default:    bits = 4'h1;
        endcase
        return bits;
    endfunction : lane_bits

    // ----------------
    // pin synchronisers
    // ----------------
    logic [1:0] cs_meta;
    logic [1:0] clk_meta;
    logic [3:0] dq_meta;
    logic [3:0] dq_sync;
    logic       cs_sync;
    logic       clk_sync;
    logic       cs_last;
    logic       clk_last;

    // two flops per pin; select resets low so only a real high can fall
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cs_meta  <= `SFPI_SYNC_RESET;
            clk_meta <= 2'h0;
            dq_meta  <= 4'hF;
            dq_sync  <= 4'hF;
            cs_last  <= 1'b0;
            clk_last <= 1'b0;
        end
        else
        begin
            cs_meta  <= {cs_meta[0], chip_select_n};
            clk_meta <= {clk_meta[0], serial_clk};
            dq_meta  <= data_line_in;
            dq_sync  <= dq_meta;
            cs_last  <= cs_meta[1];
            clk_last <= clk_meta[1];
        end
    end

    assign cs_sync  = cs_meta[1];
    assign clk_sync = clk_meta[1];

    logic cs_fall;
    logic clk_rise;
    logic clk_fall;

    // clock edges found by sampling; mode 0 and mode 3 look alike here
    assign cs_fall  = cs_last & ~cs_sync;
    assign clk_rise = ~clk_last & clk_sync;
    assign clk_fall = clk_last & ~clk_sync;

    // ----------------
    // mode resolution
    // ----------------
    logic        quad_wanted;
    logic        quad_active;
    logic        refused;
    sfpi_lanes_e eff_lanes;
    logic        pause_allowed;
    logic        pause_req;

    assign quad_wanted   = four_line_command_mode | (lane_mode == LANES_FOUR);
    assign refused       = quad_wanted & ~quad_enable_bit;
    assign quad_active   = quad_wanted & quad_enable_bit;
    // with quad enable set, four-line command mode forces four lanes
    assign eff_lanes     = quad_active ? LANES_FOUR : lane_mode;
    // pause pin is data line 3 only without quad enable and without a quad request
    assign pause_allowed = ~quad_enable_bit & ~quad_wanted;
    assign pause_req     = pause_allowed & ~dq_sync[3];

    // ----------------
    // link state
    // ----------------
    sfpi_link_e link_state;
    logic       link_run;

    // pause moves only with the clock low, so one raised mid-high waits
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            link_state <= LINK_UNARMED;
        end
        else
        begin
            unique case (link_state)
                LINK_UNARMED:
                    if (cs_fall)
                        link_state <= LINK_ACTIVE;
                LINK_IDLE:
                    if (cs_fall)
                        link_state <= LINK_ACTIVE;
                LINK_ACTIVE:
                    if (cs_sync)
                        link_state <= LINK_IDLE;
                    else if (pause_req & ~clk_sync)
                        link_state <= LINK_PAUSED;
                LINK_PAUSED:
                    if (cs_sync)
                        link_state <= LINK_IDLE;
                    else if (~pause_req & ~clk_sync)
                        link_state <= LINK_ACTIVE;
            endcase
        end
    end

    // shifters freeze during a pause and keep their place
    assign link_run = (link_state == LINK_ACTIVE) & ~cs_sync & ~refused;

    // ----------------
    // receive shifter
    // ----------------
    sfpi_byte_t    rx_shift;
    logic [3:0]    rx_count;
    logic [3:0]    rx_next_count;
    sfpi_byte_t    rx_next_shift;
    sfpi_stream_if rx_fill ();
    sfpi_stream_if rx_drain ();

    // input lines: line 0 alone, lines 1..0, or all four
    always_comb
    begin
        rx_next_count = rx_count + lane_bits(eff_lanes);
        unique case (eff_lanes)
            LANES_TWO:  rx_next_shift = {rx_shift[5:0], dq_sync[1:0]};
            LANES_FOUR: rx_next_shift = {rx_shift[3:0], dq_sync[3:0]};
            default:    rx_next_shift = {rx_shift[6:0], dq_sync[0]};
        endcase
    end

    // bits taken on rising clock edges outside read phases
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst | cs_sync)
        begin
            rx_shift      <= `SFPI_RX_RESET;
            rx_count      <= 4'h0;
            rx_fill.valid <= 1'b0;
            rx_fill.data  <= `SFPI_RX_RESET;
        end
        else
        begin
            rx_fill.valid <= 1'b0;
            if (link_run & clk_rise & ~read_phase)
            begin
                if (rx_next_count == `SFPI_BYTE_BITS)
                begin
                    rx_fill.data  <= rx_next_shift;
                    rx_fill.valid <= 1'b1;
                    rx_count      <= 4'h0;
                end
                else
                begin
                    rx_count <= rx_next_count;
                end
                rx_shift <= rx_next_shift;
            end
        end
    end

    // the link cannot be stalled, so a word that meets a full buffer is flagged
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            rx_overrun <= 1'b0;
        else if (rx_fill.valid & ~rx_fill.ready)
            rx_overrun <= 1'b1;
        else if (cs_fall)
            rx_overrun <= 1'b0;
    end

    sfpi_buf2 u_rx_buf
    (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .fill    (rx_fill),
        .drain   (rx_drain)
    );

    assign rx_data        = rx_drain.data;
    assign rx_valid       = rx_drain.valid;
    assign rx_drain.ready = rx_ready;

    // ----------------
    // page program byte count
    // ----------------
    // a page holds 256 bytes; the count holds at 256 and later bytes set page_overflow
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst | cs_fall)
        begin
            prog_byte_count <= 9'h000;
            page_overflow   <= 1'b0;
        end
        else if (rx_fill.valid & program_phase)
        begin
            if (prog_byte_count == `SFPI_PAGE_BYTES)
                page_overflow <= 1'b1;
            else
                prog_byte_count <= prog_byte_count + 9'h001;
        end
    end

    // ----------------
    // transmit shifter
    // ----------------
    sfpi_byte_t tx_shift;
    logic [3:0] tx_left;
    logic [3:0] step;

    assign step = lane_bits(eff_lanes);

    // a fresh byte is asked for whenever the shifter runs dry
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst | cs_sync | ~read_phase)
        begin
            tx_shift      <= `SFPI_TX_FILL;
            tx_left       <= 4'h0;
            tx_ready      <= 1'b0;
            tx_underrun   <= 1'b0;
            data_line_out <= 4'hF;
        end
        else
        begin
            tx_ready <= (tx_left == 4'h0) & ~(tx_ready & tx_valid);
            if (tx_ready & tx_valid)
            begin
                tx_shift <= tx_data;
                tx_left  <= `SFPI_BYTE_BITS;
            end
            else if (link_run & clk_fall)
            begin
                if (tx_left == 4'h0)
                    tx_underrun <= 1'b1;
                unique case (eff_lanes)
                    LANES_TWO:  data_line_out <= {2'h3, tx_shift[7:6]};
                    LANES_FOUR: data_line_out <= tx_shift[7:4];
                    default:    data_line_out <= {2'h3, tx_shift[7], 1'b1};
                endcase
                tx_shift <= (tx_left <= step) ? `SFPI_TX_FILL : tx_shift << step;
                tx_left  <= (tx_left > step) ? tx_left - step : 4'h0;
            end
        end
    end

    // ----------------
    // output enables
    // ----------------
    // only read phases drive; deselect and pause float everything
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst | cs_sync | ~read_phase | (link_state != LINK_ACTIVE))
            data_line_oe <= `SFPI_OE_OFF;
        else if (~refused)
        begin
            unique case (eff_lanes)
                LANES_TWO:  data_line_oe <= 4'h3;
                LANES_FOUR: data_line_oe <= 4'hF;
                default:    data_line_oe <= 4'h2;
            endcase
        end
    end

    // ----------------
    // status outputs
    // ----------------
    // the internal cycle is owned by the core; deselect only reports it
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            selected             <= 1'b0;
            paused               <= 1'b0;
            frame_start          <= 1'b0;
            mode_refused         <= 1'b0;
            status_write_allowed <= 1'b1;
            standby              <= 1'b1;
        end
        else
        begin
            selected     <= ~cs_sync & (link_state != LINK_UNARMED);
            paused       <= (link_state == LINK_PAUSED);
            frame_start  <= cs_fall;
            mode_refused <= ~cs_sync & refused;
            standby      <= cs_sync & ~internal_cycle_busy;
            // protect pin is data line 2 only without quad enable
            status_write_allowed <= quad_enable_bit | ~status_protect_bits | dq_sync[2];
        end
    end

endmodule : sfpi_front

`default_nettype wire

// ### rtl/sfpi_params.svh
// constants of the serial flash pin front end
`ifndef SFPI_PARAMS_SVH
`define SFPI_PARAMS_SVH

`define SFPI_BYTE_BITS     4'h8
`define SFPI_PAGE_BYTES    9'h100
`define SFPI_SYNC_RESET    2'h0
`define SFPI_RX_RESET      8'h00
`define SFPI_TX_FILL       8'hFF
`define SFPI_OE_OFF        4'h0
`define SFPI_SYS_CLK_NS    50
`define SFPI_LINK_CLK_NS   400

`endif

// ### rtl/sfpi_pkg.sv
// types shared by the serial flash pin front end
package sfpi_pkg;

    // number of data lines carrying one transfer beat
    typedef enum logic [1:0]
    {
        LANES_ONE,
        LANES_TWO,
        LANES_FOUR
    } sfpi_lanes_e;

    // select and pause state of the link
    typedef enum logic [1:0]
    {
        LINK_UNARMED,
        LINK_IDLE,
        LINK_ACTIVE,
        LINK_PAUSED
    } sfpi_link_e;

    typedef logic [7:0] sfpi_byte_t;

endpackage : sfpi_pkg

// ### rtl/sfpi_stream_if.sv
// byte stream carrier with valid and ready between front end modules
`timescale 1ns/100ps
`default_nettype none

interface sfpi_stream_if;
    import sfpi_pkg::*;

    sfpi_byte_t data;
    logic       valid;
    logic       ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);

endinterface : sfpi_stream_if

`default_nettype wire

// ### testbench/sfpi_front_props.sv
// checker of the serial flash pin front end
`timescale 1ns/100ps
`default_nettype none

module sfpi_front_props
    import sfpi_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    // link pins
    input wire logic        chip_select_n,
    input wire logic [3:0]  data_line_in,
    input wire logic [3:0]  data_line_oe,
    // configuration
    input wire logic        quad_enable_bit,
    input wire logic        four_line_command_mode,
    input wire sfpi_lanes_e lane_mode,
    input wire logic        read_phase,
    input wire logic        status_protect_bits,
    input wire logic        internal_cycle_busy,
    // status
    input wire logic        paused,
    input wire logic        frame_start,
    input wire logic        status_write_allowed,
    input wire logic        standby,
    input wire logic [8:0]  prog_byte_count,
    input wire logic        page_overflow
);
    // ----------------
    // port relations
    // ----------------
    // levels cross sync and output flops
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_deselect_float: assert property (chip_select_n [*5] |-> data_line_oe == 4'h0)
        else $error("oe while deselected");
    chk_idle_input: assert property (!read_phase [*3] |-> data_line_oe == 4'h0)
        else $error("oe outside read");
    chk_single_lane: assert property (data_line_oe != 4'h0 && lane_mode == LANES_ONE
        && !four_line_command_mode |-> data_line_oe == 4'h2) else $error("single drive");
    chk_dual_lane: assert property (data_line_oe != 4'h0 && lane_mode == LANES_TWO
        && !four_line_command_mode |-> data_line_oe == 4'h3) else $error("dual drive");
    chk_quad_gate: assert property (((lane_mode == LANES_FOUR || four_line_command_mode)
        && !quad_enable_bit) [*3] |-> data_line_oe == 4'h0) else $error("quad not gated");
    chk_pause_float: assert property (paused [*2] |-> data_line_oe == 4'h0)
        else $error("oe while paused");
    chk_quad_nopause: assert property (quad_enable_bit [*3] |-> !paused)
        else $error("pause under quad");
    chk_protect_pin: assert property ((!quad_enable_bit && status_protect_bits && !data_line_in[2]) [*5]
        |-> !status_write_allowed) else $error("protect ignored");
    chk_quad_noprot: assert property (quad_enable_bit [*5] |-> status_write_allowed)
        else $error("protect honoured");
    chk_busy_awake: assert property (internal_cycle_busy [*4] |-> !standby)
        else $error("standby while busy");
    chk_frame_pulse: assert property ($fell(chip_select_n) |-> ##[1:4] frame_start ##1 !frame_start)
        else $error("no frame pulse");
    chk_page_cap: assert property ($rose(page_overflow) |-> prog_byte_count == 9'h100)
        else $error("early overflow");
endmodule : sfpi_front_props

bind sfpi_front sfpi_front_props i_props
(
    .sys_clk(sys_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n), .data_line_in(data_line_in),
    .data_line_oe(data_line_oe), .quad_enable_bit(quad_enable_bit), .lane_mode(lane_mode),
    .four_line_command_mode(four_line_command_mode), .read_phase(read_phase), .paused(paused),
    .status_protect_bits(status_protect_bits), .internal_cycle_busy(internal_cycle_busy),
    .frame_start(frame_start), .status_write_allowed(status_write_allowed), .standby(standby),
    .prog_byte_count(prog_byte_count), .page_overflow(page_overflow)
);

`default_nettype wire

// ### testbench/sfpi_front_tb_top.sv
// self-checking testbench of the serial flash pin front end
`timescale 1ns/100ps
`default_nettype none

module sfpi_front_tb_top
    import sfpi_pkg::*;
();
    // ----------------
    // bench and tests
    // ----------------
    logic sys_clk = 1'b0, sys_rst = 1'b1, quad_enable_bit = 1'b0, four_line_command_mode = 1'b0;
    logic read_phase = 1'b0, program_phase = 1'b0, status_protect_bits = 1'b0, internal_cycle_busy = 1'b0;
    logic rx_ready = 1'b1, tx_valid = 1'b0, tx_take = 1'b0;
    sfpi_lanes_e lane_mode = LANES_ONE;
    sfpi_byte_t  tx_data = 8'h00, rx_q[$], tx_q[$];
    wire sfpi_byte_t rx_data;
    wire logic [3:0] wire_level, data_line_out, data_line_oe;
    wire logic [8:0] prog_byte_count;
    wire logic chip_select_n, serial_clk, rx_valid, tx_ready, selected, paused, frame_start, mode_refused;
    wire logic status_write_allowed, standby, page_overflow, rx_overrun, tx_underrun;
    int miscompares = 0, checks_done = 0;
    logic [7:0] rb;
    logic [3:0] sm;

    sfpi_front i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
        .serial_clk(serial_clk), .data_line_in(wire_level), .data_line_out(data_line_out),
        .data_line_oe(data_line_oe), .quad_enable_bit(quad_enable_bit), .lane_mode(lane_mode),
        .four_line_command_mode(four_line_command_mode), .read_phase(read_phase), .program_phase(program_phase),
        .status_protect_bits(status_protect_bits), .internal_cycle_busy(internal_cycle_busy),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .selected(selected), .paused(paused), .frame_start(frame_start),
        .mode_refused(mode_refused), .status_write_allowed(status_write_allowed), .standby(standby),
        .prog_byte_count(prog_byte_count), .page_overflow(page_overflow), .rx_overrun(rx_overrun),
        .tx_underrun(tx_underrun));
    sfpi_host_model i_host (.data_line_out(data_line_out), .data_line_oe(data_line_oe),
        .chip_select_n(chip_select_n), .serial_clk(serial_clk), .wire_level(wire_level));

    initial forever #25 sys_clk = ~sys_clk;

    // handshakes sampled mid-cycle
    always @(negedge sys_clk)
    begin
        if (rx_valid === 1'b1 && rx_ready) rx_q.push_back(rx_data);
        tx_take = tx_valid && tx_ready === 1'b1;
    end

    // byte feeder
    always @(posedge sys_clk)
    begin
        #1;
        if (tx_take) tx_q.delete(0);
        tx_valid = tx_q.size() != 0;
        tx_data = tx_valid ? tx_q[0] : 8'h00;
    end

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task check(input logic [8:0] got, input logic [8:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic rx_expect(input logic [7:0] e);
        for (int k = 0; k < 40 && rx_q.size() == 0; k++) @(posedge sys_clk);
        if (rx_q.size() == 0) check(9'h1FF, {1'b0, e});
        else check({1'b0, rx_q.pop_front()}, {1'b0, e});
    endtask : rx_expect

    task automatic bits(input logic [7:0] b, input int lo, input logic p);
        for (int i = lo; i < lo + 4; i++) i_host.beat(4'hD, {p, 2'h2, b[7 - i]}, sm);
    endtask : bits

    task end_sim();
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    initial
    begin
        #3000000;
        miscompares++;
        end_sim();
    end

    initial
    begin
        tick(6);
        sys_rst = 1'b0;
        i_host.xfer(1, 1'b0, 8'hA5, rb);
        check(9'(selected), 9'h0);
        i_host.close_frame();
        check(9'(rx_q.size()), 9'h0);
        tick(1);
        rx_ready = 1'b0;
        i_host.open_frame();
        tick(4);
        check(9'(selected), 9'h1);
        i_host.xfer(1, 1'b0, 8'h9F, rb);
        i_host.xfer(1, 1'b0, 8'h01, rb);
        i_host.xfer(1, 1'b0, 8'hE7, rb);
        tick(8);
        check(9'(rx_overrun), 9'h1);
        rx_ready = 1'b1;
        rx_expect(8'h9F);
        rx_expect(8'h01);
        tick(8);
        check(9'(rx_q.size()), 9'h0);
        i_host.close_frame();
        // dual, mode 3
        tick(1);
        lane_mode = LANES_TWO;
        i_host.mode3 = 1'b1;
        i_host.open_frame();
        i_host.xfer(2, 1'b0, 8'h6B, rb);
        i_host.xfer(2, 1'b0, 8'hD2, rb);
        i_host.close_frame();
        i_host.mode3 = 1'b0;
        rx_expect(8'h6B);
        rx_expect(8'hD2);
        // quad refused
        for (int k = 0; k < 2; k++)
        begin
            tick(1);
            lane_mode = k ? LANES_ONE : LANES_FOUR;
            four_line_command_mode = k[0];
            i_host.open_frame();
            i_host.xfer(4, 1'b0, 8'h5A, rb);
            tick(8);
            check(9'(mode_refused), 9'h1);
            i_host.close_frame();
            check(9'(rx_q.size()), 9'h0);
        end
        // quad enabled
        tick(1);
        four_line_command_mode = 1'b0;
        lane_mode = LANES_FOUR;
        quad_enable_bit = 1'b1;
        status_protect_bits = 1'b1;
        i_host.open_frame();
        i_host.xfer(4, 1'b0, 8'h30, rb);
        check(9'(paused), 9'h0);
        check(9'(status_write_allowed), 9'h1);
        i_host.close_frame();
        rx_expect(8'h30);
        // page program, one byte over
        tick(1);
        lane_mode = LANES_ONE;
        four_line_command_mode = 1'b1;
        program_phase = 1'b1;
        i_host.open_frame();
        for (int i = 0; i < 257; i++)
        begin
            i_host.xfer(4, 1'b0, 8'(i), rb);
            if (i == 0) tick(6);
            if (i == 0) check(prog_byte_count, 9'h001);
        end
        tick(8);
        check(prog_byte_count, 9'h100);
        check(9'(page_overflow), 9'h1);
        check(9'(rx_q.size()), 9'h101);
        i_host.close_frame();
        rx_q.delete();
        // protect pin
        tick(1);
        four_line_command_mode = 1'b0;
        program_phase = 1'b0;
        quad_enable_bit = 1'b0;
        i_host.pins(1'b1, 1'b0);
        tick(8);
        check(9'(status_write_allowed), 9'h0);
        i_host.pins(1'b1, 1'b1);
        tick(8);
        check(9'(status_write_allowed), 9'h1);
        status_protect_bits = 1'b0;
        // single read, then underrun
        i_host.open_frame();
        tx_q = '{8'h3C, 8'h81};
        tick(1);
        read_phase = 1'b1;
        i_host.beat(4'hC, 4'hC, sm);
        i_host.xfer(1, 1'b1, 8'h00, rb);
        check({1'b0, rb}, 9'h03C);
        i_host.xfer(1, 1'b1, 8'h00, rb);
        check({1'b0, rb}, 9'h081);
        i_host.xfer(1, 1'b1, 8'h00, rb);
        check({1'b0, rb}, 9'h0FF);
        check(9'(tx_underrun), 9'h1);
        tick(1);
        read_phase = 1'b0;
        i_host.close_frame();
        // pause mid-byte
        i_host.open_frame();
        bits(8'hC6, 0, 1'b1);
        i_host.pins(1'b0, 1'b1);
        tick(10);
        check(9'(paused), 9'h1);
        bits(8'h5A, 4, 1'b0);
        i_host.pins(1'b1, 1'b1);
        tick(10);
        check(9'(paused), 9'h0);
        bits(8'hC6, 4, 1'b1);
        i_host.close_frame();
        rx_expect(8'hC6);
        // busy while deselected
        tick(1);
        internal_cycle_busy = 1'b1;
        tick(6);
        check(9'(standby), 9'h0);
        internal_cycle_busy = 1'b0;
        tick(6);
        check(9'(standby), 9'h1);
        end_sim();
    end
endmodule : sfpi_front_tb_top

`default_nettype wire

// ### testbench/sfpi_host_model.sv
// serial bus host model driving select, clock and data lines
`timescale 1ns/100ps
`default_nettype none

module sfpi_host_model
(
    // lines from the front end
    input  wire logic [3:0] data_line_out,
    input  wire logic [3:0] data_line_oe,
    // lines to the front end
    output var  logic       chip_select_n,
    output var  logic       serial_clk,
    output wire logic [3:0] wire_level
);
    // ----------------
    // wire and frames
    // ----------------
    logic [3:0] hdrv      = 4'hC;
    logic [3:0] hval      = 4'hC;
    logic [3:0] float_pat = 4'h5;
    logic       wp_n      = 1'b1;
    logic       pause_n   = 1'b1;
    logic       mode3     = 1'b0;

    // low from power-up: no fall yet
    initial
    begin
        chip_select_n = 1'b0;
        serial_clk    = 1'b0;
    end

    // undriven lines toggle
    initial forever #25 float_pat = ~float_pat;
    assign wire_level = (hdrv & hval) | (~hdrv & data_line_oe & data_line_out) | (~hdrv & ~data_line_oe & float_pat);

    task pins(input logic p, input logic w);
        pause_n = p;
        wp_n = w;
        hval[3:2] = {p, w};
    endtask : pins

    task open_frame();
        serial_clk = mode3;
        #200 chip_select_n = 1'b0;
        #200 serial_clk = 1'b0;
    endtask : open_frame

    task close_frame();
        #200 serial_clk = mode3;
        #200 chip_select_n = 1'b1;
        hdrv = 4'hC;
        hval[3:2] = {pause_n, wp_n};
        #400;
    endtask : close_frame

    // sample just before the fall
    task automatic beat(input logic [3:0] m, input logic [3:0] v, output logic [3:0] s);
        hdrv = m;
        hval = v;
        #200 serial_clk = 1'b1;
        #195 s = wire_level;
        #5 serial_clk = 1'b0;
    endtask : beat

    task automatic xfer(input int n, input logic rd, input logic [7:0] wb, output logic [7:0] rb);
        logic [3:0] m;
        logic [3:0] v;
        logic [3:0] s;
        for (int i = 0; i < 8 / n; i++)
        begin
            m = rd ? 4'h0 : 4'((1 << n) - 1);
            v = 4'(wb >> (8 - n * (i + 1)));
            if (n != 4)
            begin
                m[3:2] = 2'h3; // pin levels kept
                v[3:2] = {pause_n, wp_n};
            end
            beat(m, v, s);
            rb = (n == 1) ? {rb[6:0], s[1]} : (n == 2) ? {rb[5:0], s[1:0]} : {rb[3:0], s};
        end
    endtask : xfer
endmodule : sfpi_host_model

`default_nettype wire
